// [rtl/flyback_prot.sv]
// Flyback gate control with burst, current limit, valley turn-on and fault handling.
// Assumes comparator decisions as levels and a simple strobe register port.
//
// Behaviour
// - Stop gate below stop trip, resume above start
// - End pulse when sense reaches 0.65V
// - Ignore current sense 350ns after turn-on
// - Overcurrent compensation only high line, above 2.9V
// - Auto-recovery faults retry at each turn-on
// - Latched fault clears only after power-down reset
// - Overload after 4.2V held past debounce
// - Overload releases on fourth turn-off crossing
// - Short circuit: 4.2V over 16ms, supply below 10V
// - Supply overvoltage holds gate off until turn-on
// - Aux falling edge through 0.05V turns gate on
// - Sample aux current 2us after turn-off
// - Four successive aux overvoltages trip auto fault
// - Over temperature disables gate until cooled
// - Latch pin low latches off until repowered
// - Timer oscillator times debounces and soft-start
// - Timer counts give 4.6ms, 30ms, 0.47s scaled
// - Supply thresholds 18V on, 8V off
`timescale 1ns/100ps
module flyback_prot
	import flyback_prot_pkg::*;
#(
	parameter int SHORT_CIRCUIT_PROTECT_LIMIT    = flyback_prot_pkg::SHORT_CIRCUIT_PROTECT_CYC,
	parameter int RESTART_LIMIT = flyback_prot_pkg::RESTART_CYC
) (
	// Clock and reset
	input  wire logic                     i_core_clk,
	input  wire logic                     i_rst_b,
	// Comparator decisions
	input  wire flyback_prot_pkg::comp_s  i_comp,
	// Register port
	input  wire logic [3:0]               i_addr,
	input  wire logic [31:0]              i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [31:0]              o_rdata,
	// Power stage controls and interrupt
	output logic                          o_flyback_gate_output,
	output logic                          o_ocp_comp_enable,
	output logic                          o_pfc_gate_disable,
	output logic                          o_soft_start,
	output logic                          o_irq
);
	import flyback_prot_pkg::*;

	localparam int SHORT_CIRCUIT_PROTECT_W = $clog2(SHORT_CIRCUIT_PROTECT_LIMIT + 1);
	localparam int RST_W  = $clog2(RESTART_LIMIT + 1);

	// Refuse counts the counters cannot serve
	if (SHORT_CIRCUIT_PROTECT_LIMIT < 2 || RESTART_LIMIT < 2)
		$error("flyback_prot: SHORT_CIRCUIT_PROTECT_LIMIT and RESTART_LIMIT must be at least 2");

	comp_s              s;
	supply_e            sup;
	supply_e            next_sup;
	fault_s             flt;
	logic               next_gate;
	logic               timer_prev;
	logic               aux_prev;
	logic               burst_off;
	logic               pdr_seen;
	logic [7:0]         ctrl;
	logic [EVT_W-1:0]   irq_stat;
	logic [EVT_W-1:0]   irq_mask;
	logic [EVT_W-1:0]   ev;
	logic [7:0]         blank_cnt;
	logic [8:0]         samp_cnt;
	logic [2:0]         aux_cnt;
	logic [1:0]         olp_div;
	logic [8:0]         olp_ticks;
	logic [12:0]        pfc_ticks;
	logic [5:0]         ss_ticks;
	logic [SHORT_CIRCUIT_PROTECT_W-1:0]  short_circuit_protect_cnt;
	logic [RST_W-1:0]   off_cnt;
	logic               tick;
	logic               on_edge;
	logic               supply_lockout_threshold_edge;
	logic               block;
	logic               valley;
	logic               sample_now;
	logic               olp_trip;
	logic               short_circuit_protect_trip;
	logic               aux_trip;
	logic               olp_release;

	sync_bank #(
		.W ($bits(comp_s))
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_d        (i_comp),
		.o_q        (s)
	);

	// Edge history of oscillator and aux comparator
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			timer_prev <= 1'b0;
			aux_prev   <= 1'b0;
		end
		else
		begin
			timer_prev <= s.timer_osc;
			aux_prev   <= s.aux_zc;
		end
	end

	// one tick per rising edge of the timer oscillator
	assign tick = s.timer_osc & ~timer_prev;

	always_comb
	begin
		next_sup = sup;
		case (sup)
			SUP_RESET: if (s.vcc_on) next_sup = SUP_ON;
			SUP_OFF:   if (s.vcc_on) next_sup = SUP_ON;
			SUP_ON:    if (s.vcc_supply_lockout_threshold) next_sup = SUP_OFF;
			default:   next_sup = SUP_RESET;
		endcase
		if (s.vcc_pdr)
			next_sup = SUP_RESET;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			sup <= SUP_RESET;
		else
			sup <= next_sup;
	end

	assign on_edge   = (sup != SUP_ON) && (next_sup == SUP_ON);
	assign supply_lockout_threshold_edge = (sup == SUP_ON) && (next_sup != SUP_ON);

	// burst hold: stop trip sets, start trip releases
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			burst_off <= 1'b0;
		else if (s.fb_stop)
			burst_off <= 1'b1;
		else if (s.fb_start)
			burst_off <= 1'b0;
	end

	// any fault, lockout or stop trip blocks the gate
	assign block = (sup != SUP_ON) | burst_off | s.fb_stop | (|flt) | ~ctrl[CTRL_EN_BIT];

	// valley turn-on on the aux falling edge only
	assign valley = aux_prev & ~s.aux_zc;

	// Gate next value; restart timer covers a missing valley after start-up
	always_comb
	begin
		next_gate = 1'b0;
		if (block)
			next_gate = 1'b0;
		else if (o_flyback_gate_output)
			next_gate = ~(s.cs_limit && blank_cnt == 8'h00);
		else
			next_gate = valley | (off_cnt == RST_W'(RESTART_LIMIT - 1));
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_flyback_gate_output <= 1'b0;
		else
			o_flyback_gate_output <= next_gate;
	end

	// Off-time counter for the restart pulse
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			off_cnt <= '0;
		else if (o_flyback_gate_output || block)
			off_cnt <= '0;
		else if (off_cnt != RST_W'(RESTART_LIMIT - 1))
			off_cnt <= off_cnt + 1'b1;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			blank_cnt <= 8'h00;
		else if (next_gate && !o_flyback_gate_output)
			blank_cnt <= 8'(BLANK_CYC);
		else if (blank_cnt != 8'h00)
			blank_cnt <= blank_cnt - 1'b1;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			samp_cnt <= 9'h000;
		else if (o_flyback_gate_output && !next_gate)
			samp_cnt <= 9'(SAMPLE_CYC);
		else if (samp_cnt != 9'h000)
			samp_cnt <= samp_cnt - 1'b1;
	end

	assign sample_now = (samp_cnt == 9'h001);

	// successive overvoltage samples; a clean sample restarts the count
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			aux_cnt <= 3'h0;
		else if (on_edge || aux_trip)
			aux_cnt <= 3'h0;
		else if (sample_now)
			aux_cnt <= s.aux_ovp ? aux_cnt + 1'b1 : 3'h0;
	end

	assign aux_trip = sample_now && s.aux_ovp && aux_cnt == 3'(AUX_OVP_CNT - 1);

	// overload debounce in timer ticks, trip only past the full count
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			olp_ticks <= 9'h000;
		else if (!s.fb_olp)
			olp_ticks <= 9'h000;
		else if (tick && olp_ticks != 9'(OLP_TICKS))
			olp_ticks <= olp_ticks + 1'b1;
	end

	assign olp_trip = s.fb_olp && olp_ticks == 9'(OLP_TICKS);

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			short_circuit_protect_cnt <= '0;
		else if (!s.fb_olp)
			short_circuit_protect_cnt <= '0;
		else if (short_circuit_protect_cnt != SHORT_CIRCUIT_PROTECT_W'(SHORT_CIRCUIT_PROTECT_LIMIT))
			short_circuit_protect_cnt <= short_circuit_protect_cnt + 1'b1;
	end

	assign short_circuit_protect_trip = short_circuit_protect_cnt == SHORT_CIRCUIT_PROTECT_W'(SHORT_CIRCUIT_PROTECT_LIMIT) && s.vcc_below10;

	// turn-off crossings counted while overload holds
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			olp_div <= 2'h0;
		else if (!flt.overload_protect)
			olp_div <= 2'h0;
		else if (supply_lockout_threshold_edge)
			olp_div <= olp_div + 1'b1;
	end

	assign olp_release = supply_lockout_threshold_edge && olp_div == 2'(OLP_DIV - 1);

	// Power-down reset memory; turn-on clears it first, else the first start-up would unlatch every later restart
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			pdr_seen <= 1'b0;
		else if (on_edge)
			pdr_seen <= 1'b0;
		else if (sup == SUP_RESET)
			pdr_seen <= 1'b1;
	end

	// Fault flags; a trip in the clearing cycle wins
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			flt <= '0;
		else
		begin
			flt.overload_protect       <= olp_trip | (flt.overload_protect & ~olp_release);
			flt.short_circuit_protect      <= short_circuit_protect_trip | (flt.short_circuit_protect & ~on_edge);
			flt.vcc_ovp   <= s.vcc_ovp | (flt.vcc_ovp & ~on_edge);
			flt.aux_ovp   <= aux_trip | (flt.aux_ovp & ~on_edge);
			flt.otp       <= s.otp;
			// cleared only by repower with pin released
			flt.ext_latch <= s.latch_low | (flt.ext_latch & ~(pdr_seen & on_edge & s.latch_high));
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_ocp_comp_enable <= 1'b0;
		else
			o_ocp_comp_enable <= s.high_line & s.fb_ocp_comp;
	end

	// soft-start window from each turn-on, in timer ticks
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ss_ticks <= 6'h00;
		else if (on_edge)
			ss_ticks <= 6'h00;
		else if (tick && ss_ticks != 6'(SS_TICKS))
			ss_ticks <= ss_ticks + 1'b1;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_soft_start <= 1'b0;
		else
			o_soft_start <= (sup == SUP_ON) && ss_ticks != 6'(SS_TICKS);
	end

	// PFC turn-off debounce, released at once when load returns
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			pfc_ticks <= 13'h0000;
		else if (!s.fb_pfc_off)
			pfc_ticks <= 13'h0000;
		else if (tick && pfc_ticks != 13'(PFC_TICKS))
			pfc_ticks <= pfc_ticks + 1'b1;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_pfc_gate_disable <= 1'b0;
		else
			o_pfc_gate_disable <= s.fb_pfc_off && pfc_ticks == 13'(PFC_TICKS);
	end

	// Events are the set terms of each flag, so a held fault reports once
	assign ev = {s.fb_stop & ~burst_off,
		s.latch_low & ~flt.ext_latch,
		s.otp & ~flt.otp,
		aux_trip & ~flt.aux_ovp,
		s.vcc_ovp & ~flt.vcc_ovp,
		short_circuit_protect_trip & ~flt.short_circuit_protect,
		olp_trip & ~flt.overload_protect};

	// Control and mask writes
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			ctrl     <= CTRL_RST;
			irq_mask <= '0;
		end
		else if (i_wr && i_addr == REG_CTRL)
			ctrl <= i_wdata[7:0];
		else if (i_wr && i_addr == REG_IRQ_MASK)
			irq_mask <= i_wdata[EVT_W-1:0];
	end

	// Sticky status, write one to clear; a new event wins
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			irq_stat <= '0;
		else if (i_wr && i_addr == REG_IRQ_STAT)
			irq_stat <= (irq_stat & ~i_wdata[EVT_W-1:0]) | ev;
		else
			irq_stat <= irq_stat | ev;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_stat & irq_mask);
	end

	// Read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_rdata <= 32'h0000_0000;
		else if (!i_rd)
			o_rdata <= 32'h0000_0000;
		else
			case (i_addr)
				REG_CTRL:     o_rdata <= {24'h00_0000, ctrl};
				REG_STATUS:   o_rdata <= {21'h0_0000, o_flyback_gate_output, o_soft_start,
							o_pfc_gate_disable, sup == SUP_ON, burst_off, flt};
				REG_IRQ_STAT: o_rdata <= {25'h00_0000, irq_stat};
				REG_IRQ_MASK: o_rdata <= {25'h00_0000, irq_mask};
				default:      o_rdata <= 32'h0000_0000;
			endcase
	end

	// Checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence valley_seen;
		valley && !block && !o_flyback_gate_output;
	endsequence

	sequence pulse_in_blank;
		o_flyback_gate_output && blank_cnt != 8'h00 && !block;
	endsequence

	chk_burst_stop: assert property (s.fb_stop |=> !o_flyback_gate_output)
		else $error("gate high after stop trip");
	chk_cs_limit: assert property (o_flyback_gate_output && blank_cnt == 8'h00 && s.cs_limit
		|=> !o_flyback_gate_output)
		else $error("pulse not ended at current limit");
	chk_blank_hold: assert property (pulse_in_blank |=> o_flyback_gate_output)
		else $error("pulse ended inside blanking window");
	chk_blank_len: assert property ($rose(o_flyback_gate_output) |-> blank_cnt == 8'(BLANK_CYC))
		else $error("blanking window length wrong");
	chk_ocp_comp: assert property (o_ocp_comp_enable |-> $past(s.high_line) && $past(s.fb_ocp_comp))
		else $error("compensation enabled without cause");
	chk_olp_trip: assert property ($rose(flt.overload_protect) |-> $past(olp_ticks) == 9'(OLP_TICKS))
		else $error("overload tripped before debounce");
	chk_olp_release: assert property ($fell(flt.overload_protect) |-> $past(olp_div) == 2'(OLP_DIV - 1))
		else $error("overload released before fourth crossing");
	chk_short_circuit_protect_trip: assert property ($rose(flt.short_circuit_protect) |-> $past(s.vcc_below10))
		else $error("short circuit without low supply");
	chk_vcc_ovp: assert property (s.vcc_ovp |=> flt.vcc_ovp ##1 !o_flyback_gate_output)
		else $error("supply overvoltage not acted on");
	chk_valley_on: assert property (valley_seen |=> o_flyback_gate_output)
		else $error("valley did not turn gate on");
	chk_aux_sample: assert property ($fell(o_flyback_gate_output) |-> samp_cnt == 9'(SAMPLE_CYC))
		else $error("aux sample not 2us after turn-off");
	chk_aux_count: assert property ($rose(flt.aux_ovp) |-> $past(aux_cnt) == 3'(AUX_OVP_CNT - 1))
		else $error("aux fault before fourth event");
	chk_latch_hold: assert property (flt.ext_latch && !pdr_seen |=> flt.ext_latch)
		else $error("latch cleared without power-down reset");
	chk_fault_gate: assert property ((|flt) |=> !o_flyback_gate_output)
		else $error("gate high under fault");

endmodule : flyback_prot

// [pkg/flyback_prot_pkg.sv]
// Constants, register map and carriers of the flyback protection and gate control.
// Assumes a 200 MHz core clock and comparator decisions made outside this logic.
package flyback_prot_pkg;

	// Core clock and fixed analog-derived timings
	localparam int CORE_CLK_MHZ  = 200;
	localparam int BLANK_NS      = 350;
	localparam int BLANK_CYC     = (BLANK_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int SAMPLE_NS     = 2000;
	localparam int SAMPLE_CYC    = (SAMPLE_NS * CORE_CLK_MHZ) / 1000;
	localparam int SHORT_CIRCUIT_PROTECT_MS       = 16;
	localparam int SHORT_CIRCUIT_PROTECT_CYC      = SHORT_CIRCUIT_PROTECT_MS * CORE_CLK_MHZ * 1000;
	localparam int RESTART_CYC   = 10000;

	// Timer oscillator ticks; one tick is 100 us with the smallest capacitor
	localparam int TICK_US       = 100;
	localparam int SS_US         = 4600;
	localparam int OLP_US        = 30000;
	localparam int PFC_OFF_US    = 470000;
	localparam int SS_TICKS      = SS_US / TICK_US;
	localparam int OLP_TICKS     = OLP_US / TICK_US;
	localparam int PFC_TICKS     = PFC_OFF_US / TICK_US;

	// Event counts
	localparam int OLP_DIV       = 4;
	localparam int AUX_OVP_CNT   = 4;

	// Register offsets, byte addresses
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_STATUS   = 4'h4;
	localparam logic [3:0] REG_IRQ_STAT = 4'h8;
	localparam logic [3:0] REG_IRQ_MASK = 4'hC;
	localparam logic [7:0] CTRL_RST     = 8'h01;
	localparam int         CTRL_EN_BIT  = 0;
	localparam int         EVT_W        = 7;

	// Comparator decisions, all active high
	typedef struct packed {
		logic timer_osc;    // timer_cap_pin oscillator square wave
		logic fb_pfc_off;   // feedback below PFC off level
		logic high_line;    // line detected high
		logic latch_high;   // latch pin above 1.35V
		logic latch_low;    // latch pin below 1.25V
		logic otp;          // die over temperature, with hysteresis
		logic vcc_ovp;      // supply over voltage
		logic vcc_pdr;      // supply below power_down_reset_level
		logic vcc_below10;  // supply below 10V
		logic vcc_supply_lockout_threshold;     // supply below 8V turn-off threshold
		logic vcc_on;       // supply above 18V turn-on threshold
		logic aux_ovp;      // aux current above overvoltage threshold
		logic aux_zc;       // aux pin above 0.05V
		logic cs_limit;     // current sense at 0.65V
		logic fb_olp;       // feedback at or above 4.2V
		logic fb_ocp_comp;  // feedback above 2.9V
		logic fb_start;     // feedback above start trip
		logic fb_stop;      // feedback below stop trip
	} comp_s;

	// Fault flags, also bits 5:0 of status and interrupt registers
	typedef struct packed {
		logic ext_latch;
		logic otp;
		logic aux_ovp;
		logic vcc_ovp;
		logic short_circuit_protect;
		logic overload_protect;
	} fault_s;

	typedef enum logic [1:0] {
		SUP_RESET = 2'b00,
		SUP_OFF   = 2'b01,
		SUP_ON    = 2'b10
	} supply_e;

endpackage : flyback_prot_pkg

// [rtl/sync_bank.sv]
// Two-flop synchroniser bank for comparator decisions.
// Assumes each bit is an independent level; no bit relation is kept.
`timescale 1ns/100ps
module sync_bank #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_b,
	// Data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta <= '0;
			o_q  <= '0;
		end
		else
		begin
			meta <= i_d;
			o_q  <= meta;
		end
	end

endmodule : sync_bank

// [verification/flyback_stage_model.sv]
// Behavioural flyback power stage, seen through its current sense and aux comparator outputs.
// Assumes the gate drive is sampled on the core clock rising edge; timings are given in core cycles.
`timescale 1ns/100ps
module flyback_stage_model (
	// Clock and gate drive
	input  wire logic        i_core_clk,
	input  wire logic        i_gate,
	// Stage timing in cycles, set by the bench
	input  wire logic [15:0] i_cs_dly,
	input  wire logic [15:0] i_demag,
	// Comparator views of the sense pins
	output logic             o_aux_zc = 1'b0,
	output logic             o_cs_limit = 1'b0
);
	logic [15:0] on_t = 16'h0000;
	logic [15:0] dmg  = 16'h0000;

	// Current ramps to the limit after i_cs_dly; cs_dly of zero models a leading-edge spike
	// After turn-off the aux winding rings high during demagnetisation, then falls once into the valley
	always @(posedge i_core_clk)
	begin
		if (i_gate)
		begin
			on_t <= on_t + 16'h0001;
			dmg <= 16'h0000;
			o_cs_limit <= (on_t >= i_cs_dly);
			o_aux_zc <= 1'b0;
		end
		else
		begin
			on_t <= 16'h0000;
			o_cs_limit <= 1'b0;
			// Saturating count: a stalled stage offers no second valley
			if (dmg != 16'hFFFF)
				dmg <= dmg + 16'h0001;
			o_aux_zc <= (dmg >= 16'h0002) && (dmg < i_demag);
		end
	end
endmodule : flyback_stage_model

// [verification/test_flyback_prot.sv]
// Self-checking bench of the flyback protection and gate control.
// Assumes the stage model closes the loop; comparator levels are driven here at the rising edge.
`timescale 1ns/100ps
module test_flyback_prot;
	import flyback_prot_pkg::*;
	typedef struct packed { logic [31:0] m; logic [31:0] e; } rd_note_s;
	logic        i_core_clk = 1'b0;
	logic        i_rst_b    = 1'b0;
	comp_s       cb;
	comp_s       comp;
	logic        osc        = 1'b0;
	logic        osc_en     = 1'b0;
	logic [1:0]  ph         = 2'h0;
	logic [3:0]  i_addr     = 4'h0;
	logic [31:0] i_wdata    = 32'h0;
	logic        i_wr       = 1'b0;
	logic        i_rd       = 1'b0;
	logic [31:0] o_rdata;
	logic        gate, ocp_en, pfc_dis, irq, p_zc, p_cs, ss;
	logic        rd_d       = 1'b0;
	logic        g_d        = 1'b0;
	logic [15:0] cs_dly     = 16'h0000;
	logic [15:0] demag      = 16'h012C;
	logic [7:0]  lf         = 8'h15;
	int          error_cnt = 0, compares = 0, cyc = 0, hi_cnt = 0, run = 0, last_on = 0, last_off = 0, t0;
	rd_note_s    notes[$];
	rd_note_s    nt;

	always #2.5 i_core_clk = ~i_core_clk;

	// Bench levels merged with the stage model's comparator outputs
	always_comb
	begin
		comp = cb;
		comp.timer_osc = osc;
		comp.aux_zc = p_zc;
		comp.cs_limit = p_cs;
	end

	flyback_prot #(.SHORT_CIRCUIT_PROTECT_LIMIT(50), .RESTART_LIMIT(1000)) i_dut (
		.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_comp(comp), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_flyback_gate_output(gate), .o_ocp_comp_enable(ocp_en),
		.o_pfc_gate_disable(pfc_dis), .o_soft_start(ss), .o_irq(irq));

	flyback_stage_model i_stage (.i_core_clk(i_core_clk), .i_gate(gate), .i_cs_dly(cs_dly), .i_demag(demag),
		.o_aux_zc(p_zc), .o_cs_limit(p_cs));

	// Timer oscillator, four cycles a tick, so tick counts stay short
	always @(posedge i_core_clk)
	begin
		ph <= osc_en ? ph + 2'h1 : 2'h0;
		osc <= osc_en & ~ph[1];
	end

	// Gate run lengths, read scoreboard and the hang limit
	always @(posedge i_core_clk)
	begin
		cyc <= cyc + 1;
		g_d <= gate;
		rd_d <= i_rd;
		if (gate)
			hi_cnt <= hi_cnt + 1;
		if (gate !== g_d)
		begin
			if (g_d)
				last_on <= run;
			else
				last_off <= run;
			run <= 1;
		end
		else
			run <= run + 1;
		if (rd_d)
		begin
			nt = notes.pop_front();
			check("rdata", o_rdata & nt.m, nt.e);
		end
		if (cyc == 80000)
		begin
			error_cnt++;
			end_sim();
		end
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
		end
	endtask : check

	task tick(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : tick

	task till(input int t);
		while (cyc < t) @(posedge i_core_clk);
	endtask : till

	// Strobes last one cycle; the trailing idle cycle keeps back-to-back calls apart
	task wr(input logic [3:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		tick(1);
		i_wr <= 1'b0;
		tick(1);
	endtask : wr

	task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		notes.push_back('{m, e});
		tick(1);
		i_rd <= 1'b0;
		tick(1);
	endtask : rd

	task quiet(input int n);
		int h;
		h = hi_cnt;
		tick(n);
		check("gate_idle", hi_cnt - h, 0);
	endtask : quiet

	task runs(input int n);
		int h;
		h = hi_cnt;
		tick(n);
		check("gate_runs", hi_cnt > h, 1);
	endtask : runs

	task rng(input string s, input int v, input int lo, input int hi);
		check(s, (v >= lo) && (v <= hi), 1);
	endtask : rng

	// Supply dips below turn-off, optionally to power-down reset, and climbs back over turn-on
	task sup(input logic power_down_reset_level);
		cb.vcc_on <= 1'b0;
		cb.vcc_supply_lockout_threshold <= 1'b1;
		cb.vcc_pdr <= power_down_reset_level;
		tick(10);
		cb.vcc_pdr <= 1'b0;
		cb.vcc_supply_lockout_threshold <= 1'b0;
		tick(5);
		cb.vcc_on <= 1'b1;
		tick(10);
	endtask : sup

	task end_sim;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	initial
	begin
		cb = '0;
		cb.fb_start = 1'b1;
		cb.latch_high = 1'b1;
		cb.vcc_pdr = 1'b1;
		tick(20);
		i_rst_b <= 1'b1;
		cb.vcc_pdr <= 1'b0;
		// Reset values and an unmapped hole
		rd(REG_CTRL, 32'hFF, {24'h0, CTRL_RST});
		rd(REG_IRQ_MASK, 32'h7F, 32'h0);
		rd(4'h2, 32'hFFFFFFFF, 32'h0);
		// silent below turn-on, valley and blanking once on
		quiet(1500);
		cb.vcc_on <= 1'b1;
		tick(4000);
		check("soft_start", ss, 1'b1);
		rng("valley_off", last_off, demag, demag + 8);
		rng("blank_on", last_on, BLANK_CYC, BLANK_CYC + 6);
		cs_dly <= 16'h0096;
		tick(2000);
		rng("limit_on", last_on, 150, 158);
		for (int i = 0; i < 4; i++)
		begin
			{cb.high_line, cb.fb_ocp_comp} <= i[1:0];
			tick(6);
			check("ocp_comp", ocp_en, i == 3);
		end
		// burst stop holds until start trip; event raised, masked and cleared
		wr(REG_IRQ_STAT, 32'h7F);
		cb.fb_stop <= 1'b1;
		cb.fb_start <= 1'b0;
		tick(5);
		quiet(600);
		cb.fb_stop <= 1'b0;
		quiet(600);
		rd(REG_IRQ_STAT, 32'h7F, 32'h40);
		lf = lfsr(lf);
		wr(REG_IRQ_MASK, {24'h0, lf});
		tick(3);
		check("irq", irq, lf[6]);
		rd(REG_IRQ_MASK, 32'hFFFFFFFF, {25'h0, lf[6:0]});
		wr(REG_IRQ_MASK, 32'h7F);
		tick(3);
		check("irq", irq, 1'b1);
		wr(REG_IRQ_STAT, 32'h40);
		tick(3);
		check("irq", irq, 1'b0);
		cb.fb_start <= 1'b1;
		runs(2500);
		// overload and PFC debounces counted in timer ticks
		t0 = cyc;
		osc_en <= 1'b1;
		cb.fb_olp <= 1'b1;
		cb.fb_pfc_off <= 1'b1;
		// Soft-start window of 46 ticks ends near cycle 185 of the oscillator run
		till(t0 + 180);
		check("soft_start", ss, 1'b1);
		till(t0 + 190);
		check("soft_start", ss, 1'b0);
		till(t0 + 1192);
		rd(REG_IRQ_STAT, 32'h1, 32'h0);
		till(t0 + 1208);
		rd(REG_IRQ_STAT, 32'h1, 32'h1);
		quiet(200);
		cb.fb_olp <= 1'b0;
		quiet(2000);
		till(t0 + 4 * 4698);
		check("pfc_off", pfc_dis, 1'b0);
		till(t0 + 4 * 4703);
		check("pfc_off", pfc_dis, 1'b1);
		cb.fb_pfc_off <= 1'b0;
		osc_en <= 1'b0;
		tick(5);
		check("pfc_off", pfc_dis, 1'b0);
		// overload released only at the fourth turn-off crossing
		for (int k = 1; k <= 4; k++)
		begin
			cb.vcc_on <= 1'b0;
			cb.vcc_supply_lockout_threshold <= 1'b1;
			tick(10);
			rd(REG_STATUS, 32'h1, k < 4);
			cb.vcc_supply_lockout_threshold <= 1'b0;
			cb.vcc_on <= 1'b1;
			tick(10);
		end
		runs(2500);
		// short circuit needs supply below 10V too; auto recovery at turn-on
		wr(REG_IRQ_STAT, 32'h7F);
		cb.fb_olp <= 1'b1;
		tick(100);
		rd(REG_IRQ_STAT, 32'h2, 32'h0);
		cb.vcc_below10 <= 1'b1;
		tick(70);
		rd(REG_IRQ_STAT, 32'h2, 32'h2);
		cb.fb_olp <= 1'b0;
		cb.vcc_below10 <= 1'b0;
		quiet(600);
		sup(1'b0);
		runs(2500);
		// supply overvoltage holds off until the next turn-on
		cb.vcc_ovp <= 1'b1;
		tick(6);
		cb.vcc_ovp <= 1'b0;
		quiet(600);
		sup(1'b0);
		runs(2500);
		// repeated aux overvoltage samples trip an auto fault
		wr(REG_IRQ_STAT, 32'h7F);
		cb.aux_ovp <= 1'b1;
		tick(4000);
		cb.aux_ovp <= 1'b0;
		rd(REG_IRQ_STAT, 32'h8, 32'h8);
		quiet(600);
		sup(1'b0);
		runs(2500);
		cb.otp <= 1'b1;
		tick(6);
		quiet(600);
		cb.otp <= 1'b0;
		runs(2500);
		// Gate enable bit of the control register blocks and restores switching
		wr(REG_CTRL, 32'h0);
		tick(3);
		quiet(600);
		rd(REG_CTRL, 32'hFF, 32'h0);
		wr(REG_CTRL, {24'h0, CTRL_RST});
		runs(2500);
		// latch holds through a plain restart, clears after power-down reset
		cb.latch_low <= 1'b1;
		cb.latch_high <= 1'b0;
		tick(6);
		cb.latch_low <= 1'b0;
		quiet(600);
		cb.latch_high <= 1'b1;
		sup(1'b0);
		quiet(2500);
		sup(1'b1);
		runs(2500);
		end_sim();
	end
endmodule : test_flyback_prot
